/* File: led_guard.sv */
// led string fault supervisor and soft-start sequencer with avalon-mm registers
// How it works
// - with bus idle, output dimming follows the external dimming input.
// - soft-start raises boost current limit in eight discrete steps.
// - limit starts at one ninth, adds a ninth every 2 ms.
// - a step waits until some string has conducted since the last one.
// - disabling then enabling the leds restarts soft-start at step one.
// - every channel fault is recorded in the status register at index 2.
// - faults are judged only while led feedback says operation is stable.
// - channel above selectable 3, 4 or 5 V threshold counts as shorted.
// - threshold resets to 4 V; software may disable short detection.
// - channel reaching target is good; good channel dropping below is open.
// - over-voltage or lower temperature marks every not-good channel open.
// - an open channel switches off after six dimming cycles.
// - a shorted channel, upper temperature clear, switches off after six cycles.
// - new fault with three channels already off shuts every channel down.
// - zener-bypassed string stays on unless over-voltage or lower temperature is reached.
// - input undervoltage stops switching and resets until re-enabled.
// - undervoltage returns all control and configuration to defaults.
// - at lower temperature, channels well below target are open, off later.
// - with leds enabled, upper temperature stops boost and sinks until disabled and re-enabled.
// - with leds enabled, upper temperature sets thermal flag; the block stays readable.
// - with chip enable low everything is off and the bus does not answer.
// - summary fault flag is the or of all fault bits.
// - status shows flags for exactly one and exactly two channels off.
//
// Our own choices: the Avalon-MM register port and the register addresses.
module led_guard
  import led_guard_pkg::*;
#(
  parameter int NUM_CH      = 8,           // number of led strings
  parameter int STEP_CNT    = STEP_CYCLES  // cycles per soft-start interval
)(
  input  wire logic              i_clk,            // 100 mhz clock
  input  wire logic              i_srst,           // synchronous reset, high
  input  wire logic              i_chip_en,        // chip enable pin
  input  wire logic              i_input_undervoltage_lockout, // input below 2.8 v
  input  wire logic              i_output_overvoltage_guard,   // boost at ovp limit
  input  wire logic              i_temp_low_trip,  // lower temperature reached
  input  wire logic              i_temp_high_trip, // upper temperature reached
  input  wire logic              i_bus_idle,       // both serial lines low/floating
  input  wire logic              i_pwm_in,         // external dimming input
  input  wire logic              i_pwm_sw,         // dimming from register path
  input  wire logic              i_pwm_period,     // pulse at each dimming period
  input  wire logic              i_stable,         // feedback says loop settled
  input  wire logic [NUM_CH-1:0] i_at_target,      // channel current at target
  input  wire logic [NUM_CH-1:0] i_conducting,     // channel carrying current
  input  wire logic [NUM_CH-1:0] i_above_3v,       // channel voltage above 3 v
  input  wire logic [NUM_CH-1:0] i_above_4v,       // channel voltage above 4 v
  input  wire logic [NUM_CH-1:0] i_above_5v,       // channel voltage above 5 v
  input  wire logic [9:0]        avs_address,      // byte address
  input  wire logic              avs_read,         // read strobe
  input  wire logic              avs_write,        // write strobe
  input  wire logic [31:0]       avs_writedata,    // write data
  input  wire logic [3:0]        avs_byteenable,   // byte lanes
  output logic [31:0]            avs_readdata,     // read data
  output logic                   avs_waitrequest,  // stall
  output logic [1:0]             avs_response,     // 00 ok, 10 slave error
  output logic [NUM_CH-1:0]      o_ch_en,          // current sink enables
  output logic                   o_pwm_out,        // dimming to sinks
  output logic                   o_boost_en,       // boost switching allowed
  output logic [3:0]             o_ilim_step       // limit in ninths, 1..9
);

  initial
  begin
    if (NUM_CH < 4 || NUM_CH > 16)
      $error("led_guard: NUM_CH must be 4..16");
    if (STEP_CNT < 2)
      $error("led_guard: STEP_CNT too small");
  end

  localparam int CW = $clog2(STEP_CNT + 1);

  typedef struct packed {
    logic              bl_on;
    logic [2:0]        cfg;
    logic              thermal;
    logic              lock;       // undervoltage latched, cleared by restart once it ends
    logic [3:0]        step;
    logic [CW-1:0]     tmr;
    logic              seen;       // conduction seen since last step
    ch_state_e [NUM_CH-1:0] chs;
    logic [NUM_CH-1:0] open_p;     // pending open fault
    logic [NUM_CH-1:0] short_p;    // pending short fault
    logic [NUM_CH-1:0][2:0] fcnt;  // dimming periods of pending fault
    logic              all_off;
    logic              ack;
    logic [31:0]       rdata;
    logic [1:0]        resp;
  } state_s;

  state_s s_reg;
  state_s s_next;

  // channels disabled by fault handling
  function automatic logic [4:0] count_off(input ch_state_e [NUM_CH-1:0] c);
    logic [4:0] n;
    n = 5'h0;
    for (int k = 0; k < NUM_CH; k++)
      n = n + 5'((c[k] == CH_OFF) ? 1 : 0);
    return n;
  endfunction : count_off

  logic [NUM_CH-1:0] short_now;
  logic [4:0]        n_off;
  logic              running;
  logic [7:0]        status;

  // short comparison with selected threshold
  // the three comparator levels arrive as separate inputs; only the
  // selected one is looked at, the others may toggle freely
  always_comb
  begin
    unique case (s_reg.cfg[1:0])
      THR_3V:  short_now = i_above_3v;
      THR_5V:  short_now = i_above_5v;
      default: short_now = i_above_4v;
    endcase
    if (!s_reg.cfg[2])
      short_now = '0;
  end

  assign n_off   = count_off(s_reg.chs);
  assign running = s_reg.bl_on && i_chip_en && !s_reg.thermal && !s_reg.all_off;


  // status byte, summary flag derived from the fault bits
  // built from live state, so a read always reflects the current picture
  always_comb
  begin
    status = 8'h00;
    status[ST_THERMAL_BIT] = s_reg.thermal;
    status[ST_BL_BIT]      = running;
    status[ST_ONE_OFF_BIT] = (n_off == 5'd1);
    status[ST_TWO_OFF_BIT] = (n_off == 5'd2);
    status[ST_FAULT_BIT]   = s_reg.thermal | (n_off != 5'd0) | s_reg.all_off;
  end

  always_comb
  begin
    logic fault_new;
    logic en_wr;
    fault_new = 1'b0;
    en_wr     = 1'b0;
    s_next = s_reg;
    s_next.ack = 1'b0;
    // bus slave: a request is taken while waitrequest is high and answered
    // one cycle later; read data is captured at the take so that it stands
    // in the answer cycle, when the master samples it
    if ((avs_read || avs_write) && !s_reg.ack)
    begin
      s_next.ack   = 1'b1;
      s_next.resp  = 2'b00;
      s_next.rdata = 32'h0;
      unique case (avs_address)
        CTRL_ADDR:   s_next.rdata = {31'h0, s_reg.bl_on};
        STATUS_ADDR: s_next.rdata = {24'h0, status};
        ID_ADDR:     s_next.rdata = {24'h0, ID_VALUE};
        CFG_ADDR:    s_next.rdata = {29'h0, s_reg.cfg};
        default:     s_next.resp  = 2'b10;
      endcase
    end

    // a write lands only at the edge where the master sees waitrequest low;
    // committing at the take would let an abandoned request change state
    if (avs_write && s_reg.ack && avs_byteenable[0])
    begin
      // control: a 0 to 1 edge on the enable bit restarts soft-start
      if (avs_address == CTRL_ADDR)
      begin
        s_next.bl_on = avs_writedata[CTRL_BL_ON_BIT];
        en_wr = avs_writedata[CTRL_BL_ON_BIT] && !s_reg.bl_on;
      end
      // config: the unused threshold code 3 is dropped, so the comparator
      // select never points at a missing level; the detect bit still lands
      if (avs_address == CFG_ADDR && avs_writedata[1:0] != 2'h3)
        s_next.cfg = avs_writedata[2:0];
      else if (avs_address == CFG_ADDR)
        s_next.cfg[2] = avs_writedata[2];
    end

    if (en_wr || (!s_reg.bl_on))
    begin
      s_next.step    = 4'd1;
      s_next.tmr     = '0;
      s_next.seen    = 1'b0;
      s_next.thermal = s_reg.bl_on ? s_reg.thermal : 1'b0;
      s_next.all_off = 1'b0;
      s_next.lock    = 1'b0;
      for (int k = 0; k < NUM_CH; k++)
      begin
        s_next.chs[k]  = CH_PEND;
        s_next.fcnt[k] = 3'h0;
      end
      s_next.open_p  = '0;
      s_next.short_p = '0;
      if (en_wr)
        s_next.thermal = 1'b0;
    end
    else if (running)
    begin
      // everything below runs only while the strings are allowed to light;
      // a thermal or global shutdown freezes timers and fault state alike

      if (|(i_conducting & o_ch_en))
        s_next.seen = 1'b1;

      // step timer
      // the timer saturates at the interval end and waits there for
      // conduction, so a dark interval delays the step instead of losing it
      if (s_reg.step < 4'(SS_STEPS + 1))
      begin
        if (s_reg.tmr >= CW'(STEP_CNT - 1))
        begin
          if (s_reg.seen || (|(i_conducting & o_ch_en)))
          begin
            s_next.step = s_reg.step + 4'd1;
            s_next.tmr  = '0;
            s_next.seen = 1'b0;
          end
        end
        else
          s_next.tmr = s_reg.tmr + CW'(1);
      end

      // per-channel classification; a channel already off is left alone
      // so that its flags stay until the leds are next disabled
      for (int k = 0; k < NUM_CH; k++)
      begin
        if (s_reg.chs[k] != CH_OFF)
        begin
          if (i_at_target[k])
            s_next.chs[k] = CH_GOOD;
          if (i_stable)
          begin
            if (s_reg.chs[k] == CH_GOOD && !i_at_target[k])
              s_next.open_p[k] = 1'b1;
            if ((i_output_overvoltage_guard || i_temp_low_trip) &&
                s_reg.chs[k] != CH_GOOD && !i_at_target[k])
              s_next.open_p[k] = 1'b1;
            if (short_now[k] && !i_temp_high_trip)
              s_next.short_p[k] = 1'b1;
          end
          if (s_reg.open_p[k] || s_reg.short_p[k])
          begin
            if (i_pwm_period)
              s_next.fcnt[k] = s_reg.fcnt[k] + 3'h1;
            if (s_reg.fcnt[k] == 3'(FAULT_PWM_CYCLES - 1) && i_pwm_period)
            begin
              s_next.chs[k] = CH_OFF;
              fault_new = 1'b1;
            end
          end
        end
      end

      // fourth fault shuts all
      // n_off still counts the channels off before this cycle's new fault
      if (fault_new && n_off >= 5'(MAX_OFF_BEFORE_ALL))
        s_next.all_off = 1'b1;
    end

    // upper temperature trip
    // gated by the registered bl_on, so a trip in the same cycle as a
    // re-enable write is not latched
    if (i_temp_high_trip && s_reg.bl_on && i_chip_en)
      s_next.thermal = 1'b1;

    // undervoltage returns defaults
    // clearing bl_on makes the restart branch reset the rest next cycle
    if (i_input_undervoltage_lockout)
    begin
      s_next.bl_on = 1'b0;
      s_next.cfg   = CFG_RESET;
      s_next.lock  = 1'b1;
    end

    // chip enable low: bus ignored, state cleared
    // this comes last so nothing above can answer a disabled bus
    if (!i_chip_en)
    begin
      s_next.ack   = 1'b0;
      s_next.bl_on = 1'b0;
      s_next.cfg   = CFG_RESET;
    end
  end

  // state register
  // reset loads the same defaults that undervoltage and enable-low restore,
  // so software sees one consistent picture after any of them
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      s_reg         <= '0;
      s_reg.cfg     <= CFG_RESET;
      s_reg.step    <= 4'd1;
      for (int k = 0; k < NUM_CH; k++)
        s_reg.chs[k] <= CH_PEND;
    end
    else
      s_reg <= s_next;
  end

  // outputs; waitrequest drops only in the ack cycle, which never follows a take with chip enable low
  // waitrequest is combinational from a flop, so it has no path from the
  // master's strobes and cannot form a loop with a combinational master
  assign avs_waitrequest = !s_reg.ack;
  assign avs_readdata    = s_reg.rdata;
  assign avs_response    = s_reg.resp;
  assign o_boost_en      = running && !i_input_undervoltage_lockout;
  assign o_ilim_step     = s_reg.step;
  // dimming source: pin when bus idle
  assign o_pwm_out       = i_chip_en && (i_bus_idle ? i_pwm_in : (running && i_pwm_sw));


  // sinks on unless fault-disabled or globally off
  // in plain dimming mode the sinks run without the enable bit, since
  // no host is there to set it
  always_comb
  begin
    for (int k = 0; k < NUM_CH; k++)
      o_ch_en[k] = i_chip_en && (running || i_bus_idle) && !s_reg.thermal &&
                   !s_reg.all_off && (s_reg.chs[k] != CH_OFF);
  end

endmodule : led_guard

/* File: led_guard_pkg.sv */
// constants shared by the led string protection and soft-start supervisor
package led_guard_pkg;
  // register byte addresses (index times four)
  localparam logic [7:0] CTRL_IDX   = 8'h01;
  localparam logic [7:0] STATUS_IDX = 8'h02;
  localparam logic [7:0] ID_IDX     = 8'h03;
  localparam logic [7:0] CFG_IDX    = 8'h0f;
  localparam logic [9:0] CTRL_ADDR   = {CTRL_IDX, 2'b00};
  localparam logic [9:0] STATUS_ADDR = {STATUS_IDX, 2'b00};
  localparam logic [9:0] ID_ADDR     = {ID_IDX, 2'b00};
  localparam logic [9:0] CFG_ADDR    = {CFG_IDX, 2'b00};
  // control register fields
  localparam int CTRL_BL_ON_BIT = 0;
  // config register fields: bits 1:0 threshold, bit 2 short detect enable
  localparam logic [1:0] THR_3V = 2'h0;
  localparam logic [1:0] THR_4V = 2'h1;
  localparam logic [1:0] THR_5V = 2'h2;
  localparam logic [2:0] CFG_RESET = {1'b1, THR_4V};
  // status register fields
  localparam int ST_FAULT_BIT   = 0;
  localparam int ST_THERMAL_BIT = 1;
  localparam int ST_BL_BIT      = 3;
  localparam int ST_ONE_OFF_BIT = 4;
  localparam int ST_TWO_OFF_BIT = 5;
  // arbitrary neutral identification value
  localparam logic [7:0] ID_VALUE = 8'h5a;
  // soft-start timing
  localparam int CLK_HZ       = 100_000_000;
  localparam int STEP_MS      = 2;
  localparam int STEP_CYCLES  = CLK_HZ / 1000 * STEP_MS;
  localparam int SS_STEPS     = 8;
  localparam int FAULT_PWM_CYCLES = 6;
  localparam int MAX_OFF_BEFORE_ALL = 3;
  // channel state codes
  typedef enum logic [2:0] {
    CH_PEND = 3'b001,
    CH_GOOD = 3'b010,
    CH_OFF  = 3'b100
  } ch_state_e;
endpackage : led_guard_pkg

/* File: led_guard_checker.sv */
// concurrent checks on the led supervisor ports
module led_guard_checker
  import led_guard_pkg::*;
#(
  parameter int NUM_CH   = 8, // strings
  parameter int STEP_CNT = 20 // soft-start interval
)(
  input wire logic              i_clk, // clock
  input wire logic              i_srst, // reset
  input wire logic              i_chip_en, // enable
  input wire logic              i_input_undervoltage_lockout, // low input
  input wire logic              i_temp_high_trip, // upper temperature
  input wire logic              i_bus_idle, // plain mode
  input wire logic              i_pwm_in, // dimming in
  input wire logic [9:0]        avs_address, // address
  input wire logic              avs_read, // read
  input wire logic              avs_write, // write
  input wire logic [31:0]       avs_readdata, // read data
  input wire logic              avs_waitrequest, // stall
  input wire logic [NUM_CH-1:0] o_ch_en, // sinks
  input wire logic              o_pwm_out, // dimming out
  input wire logic              o_boost_en, // boost
  input wire logic [3:0]        o_ilim_step // limit
);
  logic st_rd;

  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  // a status read is being answered this cycle
  assign st_rd = avs_read && !avs_waitrequest && avs_address == STATUS_ADDR;

  idle_pwm_a: assert property (
    i_bus_idle |-> o_pwm_out == i_pwm_in) else $error("dimming not passed through");
  step_range_a: assert property (
    o_ilim_step >= 4'h1 && o_ilim_step <= 4'h9) else $error("limit step out of range");
  step_by_one_a: assert property (
    $changed(o_ilim_step) && o_ilim_step != 4'h1 |-> o_ilim_step == $past(o_ilim_step) + 4'h1)
    else $error("limit skipped a step");
  ack_next_a: assert property (
    (avs_read || avs_write) && avs_waitrequest && i_chip_en |=> !avs_waitrequest)
    else $error("access not answered");
  no_ack_off_a: assert property (
    !i_chip_en |-> avs_waitrequest) else $error("answered while disabled");
  hot_off_a: assert property (
    i_temp_high_trip && !i_bus_idle |=> o_ch_en == '0 && !o_boost_en)
    else $error("output on while hot");
  input_undervoltage_lockout_off_a: assert property (
    i_input_undervoltage_lockout && !i_bus_idle |=> o_ch_en == '0)
    else $error("sinks on after low input");
  fault_or_a: assert property (
    st_rd && |{avs_readdata[5:4], avs_readdata[2:1]} |-> avs_readdata[0])
    else $error("summary flag missing");
  one_two_a: assert property (
    st_rd |-> !(avs_readdata[4] && avs_readdata[5])) else $error("both count flags set");

  // main scenarios reached
  cover property (o_ilim_step == 4'h9);
  cover property ($fell(o_ch_en[2]));
  cover property (i_temp_high_trip && !o_boost_en);
endmodule : led_guard_checker

bind led_guard led_guard_checker #(.NUM_CH(NUM_CH), .STEP_CNT(STEP_CNT)) u_chk (
  .i_clk, .i_srst, .i_chip_en, .i_input_undervoltage_lockout, .i_temp_high_trip,
  .i_bus_idle, .i_pwm_in, .avs_address, .avs_read, .avs_write, .avs_readdata,
  .avs_waitrequest, .o_ch_en, .o_pwm_out, .o_boost_en, .o_ilim_step);

/* File: led_string_model.sv */
// behavioural led strings and dimming oscillator on the far side
module led_string_model #(
  parameter int NUM_CH = 8, // strings
  parameter int PERIOD = 8  // clocks per dimming period
)(
  input  wire logic              i_clk,       // clock
  input  wire logic [NUM_CH-1:0] i_ch_en,     // sink enables
  input  wire logic [NUM_CH-1:0] i_open,      // strings made open
  input  wire logic [NUM_CH-1:0] i_short,     // strings made shorted
  input  wire logic              i_dark,      // no string conducts
  output logic      [NUM_CH-1:0] o_at_target, // current reached
  output logic      [NUM_CH-1:0] o_conduct,   // current flowing
  output logic      [NUM_CH-1:0] o_above,     // channel voltage high
  output logic                   o_period     // dimming period pulse
);
  int cnt = 0;

  // free-running dimming period, one pulse per period
  always_ff @(posedge i_clk)
  begin
    cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
  end
  assign o_period = (cnt == 0);

  // registered so no loop can form through the sink enables
  always_ff @(posedge i_clk)
  begin
    o_conduct   <= i_ch_en & ~i_open & {NUM_CH{~i_dark}};
    o_at_target <= i_ch_en & ~i_open & {NUM_CH{~i_dark}};
    o_above     <= i_ch_en & i_short;
  end
endmodule : led_string_model

/* File: led_guard_tb.sv */
// testbench for the led string supervisor
module led_guard_tb
  import led_guard_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STEP = 20;
  localparam int PER  = 8;
  logic clk = 0, srst = 1, en = 1, input_undervoltage_lockout = 0, hot = 0, idle = 0, pin = 0, dark = 1, output_overvoltage_guard = 0;
  logic rd = 0, wr = 0, wreq, pout, boost, per;
  logic [9:0] addr = '0;
  logic [3:0] be = 4'h1;
  logic [31:0] wdat = '0, rdat, got;
  logic [1:0] resp, gresp;
  logic [7:0] opn = '0, shrt = '0, ch_en, at_t, cond, abv;
  logic [3:0] ilim;
  int failures = 0, n_tests = 0;

`define CHK(x, y) begin n_tests++; if ((x) !== (y)) begin failures++; \
  $display("wrong value at %0t: got %0h want %0h", $time, x, y); end end

  led_guard #(.NUM_CH(8), .STEP_CNT(STEP)) i_led_guard (
    .i_clk(clk), .i_srst(srst), .i_chip_en(en), .i_input_undervoltage_lockout(input_undervoltage_lockout),
    .i_output_overvoltage_guard(output_overvoltage_guard), .i_temp_low_trip(1'b0), .i_temp_high_trip(hot),
    .i_bus_idle(idle), .i_pwm_in(pin), .i_pwm_sw(1'b1), .i_pwm_period(per),
    .i_stable(1'b1), .i_at_target(at_t), .i_conducting(cond), .i_above_3v(abv),
    .i_above_4v(abv), .i_above_5v(abv), .avs_address(addr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat),
    .avs_waitrequest(wreq), .avs_response(resp), .o_ch_en(ch_en), .o_pwm_out(pout),
    .o_boost_en(boost), .o_ilim_step(ilim));

  led_string_model #(.NUM_CH(8), .PERIOD(PER)) i_led_string_model (
    .i_clk(clk), .i_ch_en(ch_en), .i_open(opn), .i_short(shrt), .i_dark(dark),
    .o_at_target(at_t), .o_conduct(cond), .o_above(abv), .o_period(per));

  // 100 mhz clock
  initial
  begin
    forever #5 clk = ~clk;
  end

  // one avalon access, held until waitrequest is seen low; only the watchdog ends a hang
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdat <= d;
    rd <= !w;
    wr <= w;
    do
      @(posedge clk);
    while (wreq !== 1'b0);
    got = rdat;
    gresp = resp;
    rd <= 0;
    wr <= 0;
  endtask : bus

  task automatic rchk(input logic [9:0] a, input logic [31:0] e);
    bus(0, a, '0);
    `CHK(got, e)
  endtask : rchk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  // watchdog against a hung handshake
  initial
  begin
    #50us;
    failures++;
    wrap_up;
  end

  initial
  begin
    cyc(4);
    srst <= 0;
    rchk(STATUS_ADDR, 32'h0);
    rchk(CFG_ADDR, 32'h5);
    rchk(ID_ADDR, {24'h0, ID_VALUE});
    rchk(10'h3f0, 32'h0);
    `CHK(gresp, 2'b10)
    `CHK(ilim, 4'h1)
    idle <= 1;
    for (int i = 0; i < 2; i++)
    begin
      pin <= i[0];
      cyc(1);
      `CHK(pout, i[0])
    end
    idle <= 0;
    // dark strings hold soft-start, light lets it finish
    bus(1, CTRL_ADDR, 32'h1);
    cyc(3 * STEP);
    `CHK(ilim, 4'h1)
    dark <= 0;
    cyc(12 * STEP);
    `CHK(ilim, 4'h9)
    bus(1, CTRL_ADDR, 32'h0);
    bus(1, CTRL_ADDR, 32'h1);
    `CHK(ilim, 4'h1)
    cyc(4);
    opn <= 8'h04;
    cyc(4 * PER);
    `CHK(ch_en, 8'hff)
    cyc(4 * PER);
    `CHK(ch_en, 8'hfb)
    rchk(STATUS_ADDR, 32'h19);
    // short ignored while detection off, caught at 5 v
    bus(1, CFG_ADDR, 32'h0);
    shrt <= 8'h20;
    cyc(8 * PER);
    `CHK(ch_en, 8'hfb)
    bus(1, CFG_ADDR, 32'h6);
    cyc(8 * PER);
    `CHK(ch_en, 8'hdb)
    rchk(STATUS_ADDR, 32'h29);
    hot <= 1;
    cyc(2);
    `CHK({boost, ch_en}, 9'h0)
    hot <= 0;
    bus(0, STATUS_ADDR, '0);
    `CHK(got[1:0], 2'b11)
    `CHK(ch_en, 8'h00)
    opn <= '0;
    shrt <= '0;
    bus(1, CTRL_ADDR, 32'h0);
    bus(1, CTRL_ADDR, 32'h1);
    cyc(2);
    `CHK({boost, ch_en}, 9'h1ff)
    rchk(STATUS_ADDR, 32'h08);
    input_undervoltage_lockout <= 1;
    cyc(2);
    input_undervoltage_lockout <= 0;
    `CHK(ch_en, 8'h00)
    rchk(CFG_ADDR, 32'h5);
    rchk(CTRL_ADDR, 32'h0);
    en <= 0;
    @(posedge clk);
    addr <= ID_ADDR;
    rd <= 1;
    cyc(4);
    `CHK(wreq, 1'b1)
    rd <= 0;
    en <= 1;
    rchk(ID_ADDR, {24'h0, ID_VALUE});
    // a never-good string is left alone until over-voltage marks it open
    opn <= 8'h01;
    bus(1, CTRL_ADDR, 32'h1);
    cyc(8 * PER);
    `CHK(ch_en, 8'hff)
    output_overvoltage_guard <= 1;
    cyc(8 * PER);
    `CHK(ch_en, 8'hfe)
    wrap_up;
  end
endmodule : led_guard_tb
